// file: dpp_defines.svh
`ifndef DPP_DEFINES_SVH
`define DPP_DEFINES_SVH

// Register space
`define DPP_AW 6
`define DPP_DW 8
`define DPP_NREG 64
`define DPP_REG_RST 8'h00
// Pin idle levels: both strobes high
`define DPP_PIN_IDLE 21'h060000

// Control registers
`define DPP_ADDR_CTRL 6'h20
`define DPP_ADDR_RATE 6'h21

// Control field positions
`define DPP_CTL_SDO_BIT 0
`define DPP_CTL_UDOUT_BIT 1
`define DPP_CTL_MODE_LSB 2
`define DPP_CTL_MODE_MSB 4
`define DPP_CTL_KEY_BIT 5

// Operating mode codes
`define DPP_MODE_SINGLE 3'h0
`define DPP_MODE_FSK 3'h1
`define DPP_MODE_RFSK 3'h2
`define DPP_MODE_CHIRP 3'h3
`define DPP_MODE_BPSK 3'h4

// Serial instruction byte
`define DPP_SER_RD_BIT 7
`define DPP_SER_LAST 3'h7

// Timing
`define DPP_UD_PULSE_CYC 4'h8

// Keying amplitude
`define DPP_AMP_W 12
`define DPP_AMP_FULL 12'hfff
`define DPP_AMP_ZERO 12'h000

`endif

// file: dpp_host_model.sv
`timescale 1ns/100ps

module dpp_host_model (
   // Clock
   input wire logic clk_i,
   // Driven pins
   output logic wr_n_o,
   output logic rd_n_o,
   output logic [5:0] addr_o,
   output logic [7:0] data_o,
   // Seen pins
   input wire logic [7:0] pbus_i,
   input wire logic sdio_i,
   input wire logic sdo_i
);
   initial begin
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      addr_o = 6'h00;
      data_o = 8'h00;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
      addr_o <= a;
      data_o <= d;
      tick(1);
      wr_n_o <= 1'b0;
      tick(4);
      wr_n_o <= 1'b1;
      tick(4);
      data_o <= ~d;
      tick(1);
   endtask

   task automatic par_rd(input logic [5:0] a, output logic [7:0] d);
      addr_o <= a;
      rd_n_o <= 1'b0;
      tick(6);
      d = pbus_i;
      rd_n_o <= 1'b1;
      tick(5);
   endtask

   // Released data line shows the inverse, never a kind stale value
   task automatic ser(input logic rd, input logic [5:0] a,
      input logic [7:0] d, input logic three, output logic [7:0] q);
      logic [15:0] sh;
      sh = {rd, 1'b0, a, d};
      addr_o <= 6'h00;
      rd_n_o <= 1'b0;
      tick(4);
      // Link clock runs free of clk_i, 64 ns period
      for (int i = 15; i >= 0; i--) begin
         wr_n_o <= 1'b0;
         addr_o[0] <= (rd && i < 8) ? ~addr_o[0] : sh[i];
         #32;
         if (i < 8) q[i] = three ? sdo_i : sdio_i;
         wr_n_o <= 1'b1;
         #32;
      end
      wr_n_o <= 1'b0;
      tick(4);
      rd_n_o <= 1'b1;
      tick(6);
   endtask

   task automatic ser_abort(input int n);
      rd_n_o <= 1'b0;
      tick(4);
      repeat (n) begin
         wr_n_o <= 1'b0;
         addr_o[0] <= 1'b1;
         #32;
         wr_n_o <= 1'b1;
         #32;
      end
      wr_n_o <= 1'b0;
      addr_o[2] <= 1'b1;
      tick(6);
      addr_o[2] <= 1'b0;
      tick(6);
   endtask
endmodule // dpp_host_model

// file: dpp_key_ramp.sv
`timescale 1ns/100ps
`include "dpp_defines.svh"

module dpp_key_ramp #(
   parameter int AMP_W = `DPP_AMP_W,
   parameter int RATE_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic init_i,
   // Control
   input wire logic en_i,
   input wire logic key_i,
   input wire logic [RATE_W-1:0] rate_i,
   // Amplitude
   output logic [AMP_W-1:0] amp_o
);

   localparam logic [AMP_W-1:0] FULL = {AMP_W{1'b1}};
   localparam logic [AMP_W-1:0] ZERO = {AMP_W{1'b0}};

   logic [AMP_W-1:0] amp_ff;
   logic [AMP_W-1:0] nxt_amp;
   logic [RATE_W-1:0] div_ff;
   logic [RATE_W-1:0] nxt_div;
   logic tick;
   logic go_up;
   logic go_down;

   // Zero rate steps every cycle
   assign tick = (div_ff >= rate_i);
   assign nxt_div = tick ? '0 : div_ff + 1'b1;
   assign go_up = en_i && key_i && (amp_ff != FULL) && tick;
   assign go_down = en_i && !key_i && (amp_ff != ZERO) && tick;

   // Pin ignored while keying is off
   assign nxt_amp = !en_i ? FULL :
                    go_up ? amp_ff + 1'b1 :
                    go_down ? amp_ff - 1'b1 : amp_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         amp_ff <= '1;
         div_ff <= '0;
      end else if (init_i) begin
         amp_ff <= '1;
         div_ff <= '0;
      end else begin
         amp_ff <= nxt_amp;
         div_ff <= nxt_div;
      end
   end

   assign amp_o = amp_ff;

endmodule // dpp_key_ramp

// file: dpp_pkg.sv
package dpp_pkg;

   typedef logic [7:0] dpp_byte_t;

   typedef enum logic [1:0] {
      SER_INSTR,
      SER_DATA,
      SER_DONE
   } dpp_ser_state_t;

endpackage

// file: dpp_port.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "dpp_defines.svh"

// Contract
// - Parallel data bus used only in parallel mode
// - Six address bits select register, parallel only
// - Serial mode: A2 reset, A1 output, A0 data
// - Serial reset idles bus, keeps registers
// - 3-wire reads drive only serial_data_out
// - 2-wire: shared pin, each drives own phase
// - Control bit sets update_strobe direction
// - Input rising edge commits program registers
// - Output mode: eight-cycle high update pulse
// - Serial data sampled on serial clock rise
// - Chip select low gates serial clocks
// - Write strobe stores data; serial clock otherwise
// - Read strobe drives data; chip select otherwise
// - FSK: low tuning one, high tuning two
// - BPSK: low first phase, high second
// - Chirp: high freezes accumulator, low sweeps
// - Keying pin ignored unless enabled
// - Keying ramps amplitude at programmed rate
// - Port select low serial, high parallel
// - Global init resets buses and registers

module dpp_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Mode and init pins
   input wire logic port_type_select_i,
   input wire logic global_init_i,
   // Programming strobes
   input wire logic write_strobe_n_i,
   input wire logic read_strobe_n_i,
   // Address pins, low three shared with serial
   input wire logic [`DPP_AW-1:0] register_address_bus_i,
   output logic serial_data_out_o,
   output logic serial_data_out_oe_o,
   output logic serial_data_io_o,
   output logic serial_data_io_oe_o,
   // Parallel data bus
   input wire logic [`DPP_DW-1:0] parallel_data_bus_i,
   output logic [`DPP_DW-1:0] parallel_data_bus_o,
   output logic parallel_data_bus_oe_o,
   // Frequency update pin
   input wire logic update_strobe_i,
   output logic update_strobe_o,
   output logic update_strobe_oe_o,
   // Real-time control pins
   input wire logic modulation_select_pin_i,
   input wire logic amplitude_keying_pin_i,
   // Core side
   input wire logic int_update_i,
   output logic commit_o,
   output logic tuning_sel_two_o,
   output logic phase_sel_two_o,
   output logic accum_hold_o,
   output logic [`DPP_AMP_W-1:0] cos_amp_o
);

   localparam int SW = 21;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] meta_ff;
   logic [SW-1:0] sync_ff;

   assign pin_raw = {port_type_select_i, global_init_i, write_strobe_n_i,
                     read_strobe_n_i, register_address_bus_i,
                     parallel_data_bus_i, update_strobe_i,
                     modulation_select_pin_i, amplitude_keying_pin_i};

   // Strobe and data share delay, so captured data lines up with edge
   // Idle strobe levels, so leaving reset shows no false edge
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_ff <= `DPP_PIN_IDLE;
         sync_ff <= `DPP_PIN_IDLE;
      end else begin
         meta_ff <= pin_raw;
         sync_ff <= meta_ff;
      end
   end

   wire par_mode = sync_ff[20];
   wire init_s = sync_ff[19];
   wire wrb_s = sync_ff[18];
   wire rdb_s = sync_ff[17];
   wire [`DPP_AW-1:0] addr_s = sync_ff[16:11];
   wire [`DPP_DW-1:0] pdat_s = sync_ff[10:3];
   wire ud_s = sync_ff[2];
   wire msel_s = sync_ff[1];
   wire key_s = sync_ff[0];
   wire ser_mode = !par_mode;

   // Serial aliases of shared pins
   wire sclk_s = wrb_s;
   wire csn_s = rdb_s;
   wire io_rst_s = addr_s[2];
   wire sdin_s = addr_s[0];

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised levels
   logic wrb_d_ff;
   logic ud_d_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wrb_d_ff <= 1'b1;
         ud_d_ff <= 1'b0;
      end else begin
         wrb_d_ff <= wrb_s;
         ud_d_ff <= ud_s;
      end
   end

   wire wrb_rise = wrb_s && !wrb_d_ff;
   wire wrb_fall = !wrb_s && wrb_d_ff;
   wire ud_rise = ud_s && !ud_d_ff;
   wire ser_act = ser_mode && !csn_s && !io_rst_s;
   wire sclk_rise = ser_act && wrb_rise;
   wire sclk_fall = ser_act && wrb_fall;

   ////////////////////////////////////////////////////////////////////////
   // Register banks
   dpp_pkg::dpp_byte_t prog_ff [`DPP_NREG];
   dpp_pkg::dpp_byte_t act_ff [`DPP_NREG];

   wire [`DPP_DW-1:0] ctl_prog = prog_ff[`DPP_ADDR_CTRL];
   wire [`DPP_DW-1:0] ctl_act = act_ff[`DPP_ADDR_CTRL];
   wire [`DPP_DW-1:0] rate_act = act_ff[`DPP_ADDR_RATE];
   wire three_wire = ctl_prog[`DPP_CTL_SDO_BIT];
   // Direction acts at once so software can hand over the pin
   wire ud_out_mode = ctl_prog[`DPP_CTL_UDOUT_BIT];
   wire [2:0] mode_act = ctl_act[`DPP_CTL_MODE_MSB:`DPP_CTL_MODE_LSB];
   wire key_en = ctl_act[`DPP_CTL_KEY_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Serial engine
   dpp_pkg::dpp_ser_state_t st_ff;
   dpp_pkg::dpp_ser_state_t nxt_st;
   logic [2:0] cnt_ff;
   logic [`DPP_DW-1:0] sin_ff;
   logic [`DPP_DW-1:0] sout_ff;
   logic rd_ff;
   logic [`DPP_AW-1:0] saddr_ff;

   wire [`DPP_DW-1:0] sin_nxt = {sin_ff[`DPP_DW-2:0], sdin_s};
   wire byte_end = sclk_rise && (cnt_ff == `DPP_SER_LAST);
   wire ser_idle = ser_mode && (csn_s || io_rst_s);

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         dpp_pkg::SER_INSTR: begin
            if (byte_end) begin
               nxt_st = dpp_pkg::SER_DATA;
            end
         end
         dpp_pkg::SER_DATA: begin
            if (byte_end) begin
               nxt_st = dpp_pkg::SER_DONE;
            end
         end
         dpp_pkg::SER_DONE: begin
            nxt_st = dpp_pkg::SER_DONE;
         end
         default: begin
            nxt_st = dpp_pkg::SER_INSTR;
         end
      endcase
   end

   wire ser_wr = byte_end && (st_ff == dpp_pkg::SER_DATA) && !rd_ff;
   wire ser_rd_phase = (st_ff == dpp_pkg::SER_DATA) && rd_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= dpp_pkg::SER_INSTR;
         cnt_ff <= 3'h0;
         sin_ff <= `DPP_REG_RST;
         rd_ff <= 1'b0;
         saddr_ff <= 6'h00;
      end else if (init_s || ser_idle || par_mode) begin
         st_ff <= dpp_pkg::SER_INSTR;
         cnt_ff <= 3'h0;
         rd_ff <= 1'b0;
      end else if (sclk_rise) begin
         st_ff <= nxt_st;
         cnt_ff <= cnt_ff + 3'h1;
         sin_ff <= sin_nxt;
         if (byte_end && st_ff == dpp_pkg::SER_INSTR) begin
            rd_ff <= sin_nxt[`DPP_SER_RD_BIT];
            saddr_ff <= sin_nxt[`DPP_AW-1:0];
         end
      end
   end

   // Read data launched on falling clock, first bit right after instr
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sout_ff <= `DPP_REG_RST;
      end else if (sclk_fall && ser_rd_phase) begin
         if (cnt_ff == 3'h0) begin
            sout_ff <= prog_ff[saddr_ff];
         end else begin
            sout_ff <= {sout_ff[`DPP_DW-2:0], 1'b0};
         end
      end
   end

   wire drive_ok = ser_act && ser_rd_phase;
   assign serial_data_out_o = sout_ff[`DPP_DW-1];
   assign serial_data_out_oe_o = drive_ok && three_wire;
   assign serial_data_io_o = sout_ff[`DPP_DW-1];
   // Host owns the pin in the instruction phase
   assign serial_data_io_oe_o = drive_ok && !three_wire;

   ////////////////////////////////////////////////////////////////////////
   // Parallel port
   wire par_wr = par_mode && wrb_rise;
   logic [`DPP_DW-1:0] pout_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pout_ff <= `DPP_REG_RST;
      end else begin
         pout_ff <= prog_ff[addr_s];
      end
   end

   assign parallel_data_bus_o = pout_ff;
   assign parallel_data_bus_oe_o = par_mode && !rdb_s;

   ////////////////////////////////////////////////////////////////////////
   // Program register writes
   wire wr_en = par_wr || ser_wr;
   wire [`DPP_AW-1:0] wr_addr = par_mode ? addr_s : saddr_ff;
   wire [`DPP_DW-1:0] wr_data = par_mode ? pdat_s : sin_nxt;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < `DPP_NREG; i++) begin
            prog_ff[i] <= `DPP_REG_RST;
         end
      end else if (init_s) begin
         for (int i = 0; i < `DPP_NREG; i++) begin
            prog_ff[i] <= `DPP_REG_RST;
         end
      end else if (wr_en) begin
         prog_ff[wr_addr] <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency update
   wire commit = ud_out_mode ? int_update_i : ud_rise;
   logic [3:0] pulse_ff;
   logic commit_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < `DPP_NREG; i++) begin
            act_ff[i] <= `DPP_REG_RST;
         end
      end else if (init_s) begin
         for (int i = 0; i < `DPP_NREG; i++) begin
            act_ff[i] <= `DPP_REG_RST;
         end
      end else if (commit) begin
         for (int i = 0; i < `DPP_NREG; i++) begin
            act_ff[i] <= prog_ff[i];
         end
      end
   end

   // A new update restarts the pulse rather than stacking
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pulse_ff <= 4'h0;
         commit_ff <= 1'b0;
      end else if (init_s) begin
         pulse_ff <= 4'h0;
         commit_ff <= 1'b0;
      end else begin
         commit_ff <= commit;
         if (commit && ud_out_mode) begin
            pulse_ff <= `DPP_UD_PULSE_CYC;
         end else if (pulse_ff != 4'h0) begin
            pulse_ff <= pulse_ff - 4'h1;
         end
      end
   end

   assign update_strobe_o = (pulse_ff != 4'h0);
   assign update_strobe_oe_o = ud_out_mode;
   assign commit_o = commit_ff;

   ////////////////////////////////////////////////////////////////////////
   // Modulation select
   logic tsel_ff;
   logic psel_ff;
   logic hold_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tsel_ff <= 1'b0;
         psel_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         tsel_ff <= (mode_act == `DPP_MODE_FSK) && msel_s;
         psel_ff <= (mode_act == `DPP_MODE_BPSK) && msel_s;
         hold_ff <= (mode_act == `DPP_MODE_CHIRP) && msel_s;
      end
   end

   assign tuning_sel_two_o = tsel_ff;
   assign phase_sel_two_o = psel_ff;
   assign accum_hold_o = hold_ff;

   ////////////////////////////////////////////////////////////////////////
   // Shaped keying
   dpp_key_ramp #(
      .AMP_W(`DPP_AMP_W),
      .RATE_W(`DPP_DW)
   ) u_ramp (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .init_i(init_s),
      .en_i(key_en),
      .key_i(key_s),
      .rate_i(rate_act),
      .amp_o(cos_amp_o)
   );

endmodule // dpp_port

// file: dpp_port_checker.sv
`timescale 1ns/100ps

module dpp_port_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Watched ports
   input wire logic port_type_select_i,
   input wire logic global_init_i,
   input wire logic read_strobe_n_i,
   input wire logic update_strobe_i,
   input wire logic modulation_select_pin_i,
   input wire logic int_update_i,
   input wire logic parallel_data_bus_oe_o,
   input wire logic serial_data_out_oe_o,
   input wire logic serial_data_io_oe_o,
   input wire logic update_strobe_o,
   input wire logic update_strobe_oe_o,
   input wire logic commit_o,
   input wire logic tuning_sel_two_o,
   input wire logic phase_sel_two_o,
   input wire logic accum_hold_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // Repeat counts leave room for the two-stage pin synchronisers
   par_drive_a: assert property (
      (!read_strobe_n_i && port_type_select_i) [*5] |->
      parallel_data_bus_oe_o) else $error("read not driven");
   par_hiz_a: assert property (
      !port_type_select_i [*5] |-> !parallel_data_bus_oe_o)
      else $error("parallel bus driven in serial mode");
   ser_gate_a: assert property (
      (read_strobe_n_i || port_type_select_i) [*5] |->
      !serial_data_out_oe_o && !serial_data_io_oe_o)
      else $error("serial pin driven while deselected");
   ser_pin_a: assert property (
      !(serial_data_out_oe_o && serial_data_io_oe_o))
      else $error("both serial pins driven");
   ud_cause_a: assert property (
      $rose(update_strobe_o) |-> $past(int_update_i) && update_strobe_oe_o)
      else $error("update pulse without cause");
   ud_len_a: assert property (
      $rose(update_strobe_o) |-> update_strobe_o [*8])
      else $error("update pulse too short");
   ud_commit_a: assert property (
      $rose(update_strobe_i) && !update_strobe_oe_o |-> ##[2:8] commit_o)
      else $error("update edge not committed");
   sel_low_a: assert property (
      !modulation_select_pin_i [*5] |->
      !tuning_sel_two_o && !phase_sel_two_o && !accum_hold_o)
      else $error("select low ignored");
   init_clear_a: assert property (
      global_init_i [*4] |->
      !update_strobe_oe_o && !update_strobe_o && !commit_o)
      else $error("init did not clear");
endmodule // dpp_port_checker

bind dpp_port dpp_port_checker chk (.clk_i, .arst_n_i, .port_type_select_i,
   .global_init_i, .read_strobe_n_i, .update_strobe_i,
   .modulation_select_pin_i, .int_update_i, .parallel_data_bus_oe_o,
   .serial_data_out_oe_o, .serial_data_io_oe_o, .update_strobe_o,
   .update_strobe_oe_o, .commit_o, .tuning_sel_two_o, .phase_sel_two_o,
   .accum_hold_o);

// file: tb_top.sv
`timescale 1ns/100ps
`include "dpp_defines.svh"

module tb_top;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic port_type_select_i = 1'b1;
   logic global_init_i = 1'b0;
   logic ud_host = 1'b0;
   logic modulation_select_pin_i = 1'b0;
   logic amplitude_keying_pin_i = 1'b0;
   logic int_update_i = 1'b0;
   logic wr_n, rd_n, sdo_pin, sdio_pin, update_strobe_i, commit_o;
   logic sdo_o, sdo_oe, sdio_o, sdio_oe, pbus_oe, ud_o, ud_oe;
   logic tsel, psel, hold;
   logic [5:0] addr_host, addr_pin;
   logic [7:0] data_host, pbus_pin, pbus_o, q;
   logic [11:0] amp;
   int error_cnt = 0;
   int n_tests = 0;

   always #2.5 clk_i = ~clk_i;

   // Shared pins resolved from the DUT's output enables only
   assign sdio_pin = sdio_oe ? sdio_o : addr_host[0];
   assign sdo_pin = sdo_oe ? sdo_o : ~sdo_o;
   assign addr_pin = {addr_host[5:1], sdio_pin};
   assign pbus_pin = pbus_oe ? pbus_o : data_host;
   assign update_strobe_i = ud_oe ? ud_o : ud_host;

   dpp_port uut (.clk_i, .arst_n_i, .port_type_select_i, .global_init_i,
      .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
      .register_address_bus_i(addr_pin), .serial_data_out_o(sdo_o),
      .serial_data_out_oe_o(sdo_oe), .serial_data_io_o(sdio_o),
      .serial_data_io_oe_o(sdio_oe), .parallel_data_bus_i(pbus_pin),
      .parallel_data_bus_o(pbus_o), .parallel_data_bus_oe_o(pbus_oe),
      .update_strobe_i, .update_strobe_o(ud_o), .update_strobe_oe_o(ud_oe),
      .modulation_select_pin_i, .amplitude_keying_pin_i, .int_update_i,
      .commit_o, .tuning_sel_two_o(tsel), .phase_sel_two_o(psel),
      .accum_hold_o(hold), .cos_amp_o(amp));

   dpp_host_model host (.clk_i, .wr_n_o(wr_n), .rd_n_o(rd_n),
      .addr_o(addr_host), .data_o(data_host), .pbus_i(pbus_pin),
      .sdio_i(sdio_pin), .sdo_i(sdo_pin));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic t_par();
      host.par_wr(6'h21, 8'h5a);
      host.par_wr(6'h3f, 8'hc3);
      host.par_rd(6'h21, q);
      check(q, 8'h5a);
      host.par_rd(6'h3f, q);
      check(q, 8'hc3);
      $display("parallel done");
   endtask

   task automatic t_ser();
      port_type_select_i <= 1'b0;
      tick(6);
      host.ser(1'b0, 6'h10, 8'h96, 1'b0, q);
      host.ser(1'b1, 6'h10, 8'h00, 1'b0, q);
      check(q, 8'h96);
      host.ser(1'b1, 6'h21, 8'h00, 1'b0, q);
      check(q, 8'h5a);
      host.ser(1'b0, `DPP_ADDR_CTRL, 8'h01, 1'b0, q);
      host.ser(1'b1, 6'h10, 8'h00, 1'b1, q);
      check(q, 8'h96);
      host.ser_abort(5);
      host.ser(1'b1, 6'h3f, 8'h00, 1'b1, q);
      check(q, 8'hc3);
      $display("serial done");
   endtask

   task automatic t_mod();
      logic [7:0] mode [3] = '{8'h04, 8'h10, 8'h0c};
      logic [2:0] exp [3] = '{3'h4, 3'h2, 3'h1};
      int k;
      for (int m = 0; m < 3; m++) begin
         host.ser(1'b0, `DPP_ADDR_CTRL, mode[m], 1'b0, q);
         ud_host <= 1'b1;
         k = 0;
         while (commit_o !== 1'b1 && k < 12) begin
            tick(1);
            k++;
         end
         check(commit_o, 1'b1);
         if (k == 12) tally_and_finish();
         ud_host <= 1'b0;
         modulation_select_pin_i <= 1'b1;
         tick(6);
         check({tsel, psel, hold}, exp[m]);
      end
      modulation_select_pin_i <= 1'b0;
      $display("modulation done");
   endtask

   task automatic t_out();
      int cnt;
      cnt = 0;
      host.ser(1'b0, `DPP_ADDR_RATE, 8'h00, 1'b0, q);
      host.ser(1'b0, `DPP_ADDR_CTRL, 8'h22, 1'b0, q);
      check(ud_oe, 1'b1);
      check(amp, `DPP_AMP_FULL);
      int_update_i <= 1'b1;
      tick(1);
      int_update_i <= 1'b0;
      repeat (20) begin
         tick(1);
         if (ud_o === 1'b1) cnt++;
      end
      check(cnt[11:0], 12'h008);
      tick(4200);
      check(amp, `DPP_AMP_ZERO);
      amplitude_keying_pin_i <= 1'b1;
      tick(4200);
      check(amp, `DPP_AMP_FULL);
      $display("update and keying done");
   endtask

   task automatic t_init();
      global_init_i <= 1'b1;
      tick(6);
      global_init_i <= 1'b0;
      tick(6);
      check(ud_oe, 1'b0);
      host.ser(1'b1, 6'h10, 8'h00, 1'b0, q);
      check(q, `DPP_REG_RST);
      $display("init done");
   endtask

   initial begin
      tick(6);
      arst_n_i <= 1'b1;
      tick(4);
      t_par();
      t_ser();
      t_mod();
      t_out();
      t_init();
      tally_and_finish();
   end
endmodule // tb_top
